/* core/tcb_regs.svh */
// Purpose: Offsets, field positions, reset values and encodings of the threshold/edge config bank
// Assumes: Register port with 6-bit word offsets and 24-bit data words
// Notes:   Definitions only; included by bare name
`ifndef TCB_REGS_SVH
`define TCB_REGS_SVH

// Register port geometry
`define TCB_ADDR_W        6
`define TCB_DATA_W        24

// Word offsets
`define TCB_OFS_IRQ_EN4   6'h28
`define TCB_OFS_LVL01     6'h29
`define TCB_OFS_LVL23     6'h2a
`define TCB_OFS_LVL45     6'h2b
`define TCB_OFS_LVL67     6'h2c

// Threshold fields, two per register
`define TCB_LVL_W         10
`define TCB_LVL_LO_POS    0
`define TCB_LVL_HI_POS    10
`define TCB_LVL_NUM       8
`define TCB_LVL_RST       10'h000

// Edge select fields inside the enable register
`define TCB_SWITCH_INPUT_22_POS      0
`define TCB_SWITCH_INPUT_22_W        6
`define TCB_SWITCH_INPUT_22_RST      6'h00
`define TCB_SWITCH_INPUT_23_POS      6
`define TCB_SWITCH_INPUT_23_W        10
`define TCB_SWITCH_INPUT_23_RST      10'h000

// Two-bit edge select code: 00 none, 01 rising, 10 falling, 11 both
`define TCB_SEL_W         2
`define TCB_SEL_RISE_BIT  0
`define TCB_SEL_FALL_BIT  1

`endif

/* core/tcb_pkg.sv */
// Purpose: Shared types of the threshold/edge config bank
// Assumes: tcb_regs.svh gives all widths
// Notes:   Types only, no constants of its own
`include "tcb_regs.svh"

package tcb_pkg;
   typedef logic [`TCB_LVL_W-1:0]  tcb_level_t;
   typedef logic [`TCB_SEL_W-1:0]  tcb_sel_t;
   typedef logic [`TCB_DATA_W-1:0] tcb_word_t;
   typedef logic [`TCB_ADDR_W-1:0] tcb_addr_t;
endpackage

/* core/tcb_cmp_if.sv */
// Purpose: Carries one threshold comparison between the bank and a crossing detector
// Assumes: Single clock domain
// Notes:   One instance per input/threshold pair
`timescale 1ns/100ps
`default_nettype none

interface tcb_cmp_if;
   import tcb_pkg::*;
   logic       sampleValid;   // New conversion result present
   tcb_level_t sample;        // Conversion result
   tcb_level_t level;         // Threshold compared against
   tcb_sel_t   sel;           // Edge select code
   logic       hit;           // One-cycle crossing event

   modport src (output sampleValid, output sample, output level, output sel, input hit);
   modport det (input sampleValid, input sample, input level, input sel, output hit);
endinterface

`default_nettype wire

/* core/tcb_cfg_field.sv */
// Purpose: One host-writable configuration field with a fixed reset value
// Assumes: Synchronous active-low reset
// Notes:   Write strobe already decoded by the bank
`timescale 1ns/100ps
`default_nettype none

module tcb_cfg_field
   import tcb_pkg::*;
#(
   parameter int          W   = 10,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clock,    // Core clock
   input  wire logic         rst_n,    // Sync reset, active low
   input  wire logic         wrEn,     // Write strobe for this field
   input  wire logic [W-1:0] wrData,   // Field slice of the write word
   output var  logic [W-1:0] value     // Held field value
);

   if (W < 1) begin : g_bad_width
      $error("tcb_cfg_field: W must be at least 1");
   end

   logic [W-1:0] value_ff;
   logic [W-1:0] nxt_value;

   // Only the decoded strobe may change the field
   always_comb begin
      nxt_value = value_ff;
      if (wrEn) begin
         nxt_value = wrData;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         value_ff <= RST;
      end else begin
         value_ff <= nxt_value;
      end
   end

   assign value = value_ff;

endmodule

`default_nettype wire

/* core/tcb_edge_det.sv */
// Purpose: Detects threshold crossings of one input and qualifies them by the edge select code
// Assumes: Samples arrive as one-cycle valid strobes
// Notes:   First sample after reset only sets the reference side, it never fires
`timescale 1ns/100ps
`default_nettype none

module tcb_edge_det
   import tcb_pkg::*;
(
   input  wire logic clock,    // Core clock
   input  wire logic rst_n,    // Sync reset, active low
   tcb_cmp_if.det    cmp       // Sample, level, select in; hit out
);

   logic seen_ff;
   logic above_ff;
   logic hit_ff;
   logic nxt_seen;
   logic nxt_above;
   logic nxt_hit;
   logic nowAbove;
   logic rise;
   logic fall;

   // Side is judged per new result against the previous result's side
   always_comb begin
      nowAbove  = (cmp.sample >= cmp.level);
      rise      = seen_ff && !above_ff && nowAbove;
      fall      = seen_ff && above_ff && !nowAbove;
      nxt_seen  = seen_ff;
      nxt_above = above_ff;
      nxt_hit   = 1'b0;
      if (cmp.sampleValid) begin
         nxt_seen  = 1'b1;
         nxt_above = nowAbove;
         // 00 blocks both, 01 rise, 10 fall, 11 both
         nxt_hit   = (cmp.sel[`TCB_SEL_RISE_BIT] && rise)
                   || (cmp.sel[`TCB_SEL_FALL_BIT] && fall);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         seen_ff  <= 1'b0;
         above_ff <= 1'b0;
         hit_ff   <= 1'b0;
      end else begin
         seen_ff  <= nxt_seen;
         above_ff <= nxt_above;
         hit_ff   <= nxt_hit;
      end
   end

   assign cmp.hit = hit_ff;

endmodule

`default_nettype wire

/* core/tcb_bank.sv */
// Purpose: Threshold levels 0-7 and edge interrupt selects of switch inputs 22 and 23
// Assumes: Register port already decoded from the serial link, one word per cycle
// Notes:   Crossing detectors for inputs 22/23 consume the selects inside this block
//          Reads return the word one cycle after the strobe
`timescale 1ns/100ps
`default_nettype none

// Register map, one 24-bit word per offset:
//   28h [15:6] input 23 selects, [5:0] input 22 selects
//   29h level one high, level zero low
//   2Ah level three high, level two low
//   2Bh level five high, level four low
//   2Ch level seven high, level six low
//   Other offsets and reserved bits read zero
// Timing, counted in edges after the strobe edge:
//   A write is visible right after its edge
//   Read word and valid appear right after the strobe edge too
//   Hit appears right after its result's edge, irq one edge later
//   Accesses may come back to back on every cycle
// Limitations:
//   Bits 23:16 of 28h belong to supply logic kept elsewhere
//   Shared levels A to C, eight and nine arrive as ports
//   Only inputs 22 and 23 have detectors here
//   2Ch start value is a parameter; hardware leaves it open

module tcb_bank
   import tcb_pkg::*;
#(
   parameter tcb_level_t LVL67_RST = `TCB_LVL_RST   // Start value of levels six and seven
) (
   input  wire logic                 clock,           // Core clock, 250 MHz
   input  wire logic                 rst_n,           // Sync reset, active low
   // Register port
   input  wire logic                 regWrEn,         // Register write strobe
   input  wire logic                 regRdEn,         // Register read strobe
   input  wire tcb_addr_t            regAddr,         // Register word offset
   input  wire tcb_word_t            regWrData,       // Write data
   output var  tcb_word_t            regRdData,       // Read data, held until next read
   output var  logic                 regRdValid,      // Read data valid pulse
   // Conversion results
   input  wire logic                 sample23Valid,   // New result for switch_input_23
   input  wire tcb_level_t           sample23,        // Result for switch_input_23
   input  wire logic                 sample22Valid,   // New result for switch_input_22
   input  wire tcb_level_t           sample22,        // Result for switch_input_22
   // Levels kept outside this bank
   input  wire tcb_level_t           sharedLevelA,    // Mapped threshold A
   input  wire tcb_level_t           sharedLevelB,    // Mapped threshold B
   input  wire tcb_level_t           sharedLevelC,    // Mapped threshold C
   input  wire tcb_level_t           levelEight,      // Threshold eight
   input  wire tcb_level_t           levelNine,       // Threshold nine
   // Held configuration
   output var  tcb_level_t [`TCB_LVL_NUM-1:0] levels, // Levels zero to seven
   output var  logic [`TCB_SWITCH_INPUT_23_W-1:0] input23EdgeIrqSelect, // Input 23 select field
   output var  logic [`TCB_SWITCH_INPUT_22_W-1:0] input22EdgeIrqSelect, // Input 22 select field
   // Crossing events
   output var  logic [4:0]           in23Hit,         // Per-threshold events, input 23
   output var  logic [2:0]           in22Hit,         // Per-threshold events, input 22
   output var  logic                 in23Irq,         // Any event on input 23, delayed a cycle
   output var  logic                 in22Irq          // Any event on input 22, delayed a cycle
);

   // Selector counts follow from the field widths
   // A header edit that breaks the counts is refused below
   localparam int N23 = `TCB_SWITCH_INPUT_23_W / `TCB_SEL_W;
   localparam int N22 = `TCB_SWITCH_INPUT_22_W / `TCB_SEL_W;

   if (N23 != 5 || N22 != 3) begin : g_bad_fields
      $error("tcb_bank: select field widths do not give 5 and 3 selectors");
   end

   // Decoded write strobes
   logic wrIrqEn4;
   logic wrLvl01;
   logic wrLvl23;
   logic wrLvl45;
   logic wrLvl67;
   logic [`TCB_LVL_NUM-1:0] wrLvl;

   // Word offsets are exact matches; anything else is ignored on write
   // Strobe and offset are sampled together on one edge
   always_comb begin
      wrIrqEn4 = regWrEn && (regAddr == `TCB_OFS_IRQ_EN4);
      wrLvl01  = regWrEn && (regAddr == `TCB_OFS_LVL01);
      wrLvl23  = regWrEn && (regAddr == `TCB_OFS_LVL23);
      wrLvl45  = regWrEn && (regAddr == `TCB_OFS_LVL45);
      wrLvl67  = regWrEn && (regAddr == `TCB_OFS_LVL67);
      // Each word carries one even and one odd level
      wrLvl[0] = wrLvl01;
      wrLvl[1] = wrLvl01;
      wrLvl[2] = wrLvl23;
      wrLvl[3] = wrLvl23;
      wrLvl[4] = wrLvl45;
      wrLvl[5] = wrLvl45;
      wrLvl[6] = wrLvl67;
      wrLvl[7] = wrLvl67;
   end

   // Select fields; bits 23:16 of this word belong to other logic and are not kept here
   // Both fields share one strobe; the host always writes the whole word
   tcb_cfg_field #(
      .W   (`TCB_SWITCH_INPUT_23_W),
      .RST (`TCB_SWITCH_INPUT_23_RST)
   ) u_sel23 (
      .clock  (clock),
      .rst_n  (rst_n),
      .wrEn   (wrIrqEn4),
      .wrData (regWrData[`TCB_SWITCH_INPUT_23_POS +: `TCB_SWITCH_INPUT_23_W]),
      .value  (input23EdgeIrqSelect)
   );

   tcb_cfg_field #(
      .W   (`TCB_SWITCH_INPUT_22_W),
      .RST (`TCB_SWITCH_INPUT_22_RST)
   ) u_sel22 (
      .clock  (clock),
      .rst_n  (rst_n),
      .wrEn   (wrIrqEn4),
      .wrData (regWrData[`TCB_SWITCH_INPUT_22_POS +: `TCB_SWITCH_INPUT_22_W]),
      .value  (input22EdgeIrqSelect)
   );

   // Even levels take the low field, odd levels the high field, LSB at the lowest bit
   // Levels six and seven start from a parameter, the rest from zero
   // Each level is its own field, so one write touches exactly two
   for (genvar i = 0; i < `TCB_LVL_NUM; i++) begin : g_lvl
      localparam int         POS = (i % 2 == 1) ? `TCB_LVL_HI_POS : `TCB_LVL_LO_POS;
      localparam tcb_level_t RST = (i >= 6) ? LVL67_RST : `TCB_LVL_RST;
      tcb_cfg_field #(
         .W   (`TCB_LVL_W),
         .RST (RST)
      ) u_lvl (
         .clock  (clock),
         .rst_n  (rst_n),
         .wrEn   (wrLvl[i]),
         .wrData (regWrData[POS +: `TCB_LVL_W]),
         .value  (levels[i])
      );
   end

   // Read mux: reserved and unmapped bits read as zero
   // Decoding the live address keeps the read answer at one cycle
   tcb_word_t rdMux;

   always_comb begin
      rdMux = '0;
      case (regAddr)
         `TCB_OFS_IRQ_EN4: begin
            rdMux[`TCB_SWITCH_INPUT_23_POS +: `TCB_SWITCH_INPUT_23_W] = input23EdgeIrqSelect;
            rdMux[`TCB_SWITCH_INPUT_22_POS +: `TCB_SWITCH_INPUT_22_W] = input22EdgeIrqSelect;
         end
         `TCB_OFS_LVL01: begin
            rdMux[`TCB_LVL_HI_POS +: `TCB_LVL_W] = levels[1];
            rdMux[`TCB_LVL_LO_POS +: `TCB_LVL_W] = levels[0];
         end
         `TCB_OFS_LVL23: begin
            rdMux[`TCB_LVL_HI_POS +: `TCB_LVL_W] = levels[3];
            rdMux[`TCB_LVL_LO_POS +: `TCB_LVL_W] = levels[2];
         end
         `TCB_OFS_LVL45: begin
            rdMux[`TCB_LVL_HI_POS +: `TCB_LVL_W] = levels[5];
            rdMux[`TCB_LVL_LO_POS +: `TCB_LVL_W] = levels[4];
         end
         `TCB_OFS_LVL67: begin
            rdMux[`TCB_LVL_HI_POS +: `TCB_LVL_W] = levels[7];
            rdMux[`TCB_LVL_LO_POS +: `TCB_LVL_W] = levels[6];
         end
         default: begin
            rdMux = '0;
         end
      endcase
   end

   // Read data is captured on the strobe and held, so a slow serializer can shift it out
   // A write in the same cycle lands after the read, so the old word is returned
   // Valid follows the strobe one cycle later and lasts one cycle
   // Reset clears the held word so the port shows zero until the first read
   tcb_word_t rdData_ff;
   tcb_word_t nxt_rdData;
   logic      rdValid_ff;
   logic      nxt_rdValid;

   always_comb begin
      nxt_rdData  = rdData_ff;
      nxt_rdValid = regRdEn;
      if (regRdEn) begin
         nxt_rdData = rdMux;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdData_ff  <= '0;
         rdValid_ff <= 1'b0;
      end else begin
         rdData_ff  <= nxt_rdData;
         rdValid_ff <= nxt_rdValid;
      end
   end

   assign regRdData  = rdData_ff;
   assign regRdValid = rdValid_ff;

   // Thresholds seen by each input, in selector order from the low pair upward
   // Mapping of shared levels to inputs is done upstream
   tcb_level_t [N23-1:0] thr23;
   tcb_level_t [N22-1:0] thr22;

   always_comb begin
      thr23[0] = sharedLevelA;
      thr23[1] = sharedLevelB;
      thr23[2] = sharedLevelC;
      thr23[3] = levelEight;
      thr23[4] = levelNine;
      thr22[0] = sharedLevelA;
      thr22[1] = sharedLevelB;
      thr22[2] = sharedLevelC;
   end

   // Select code per pair: 00 none, 01 below to above, 10 above to below, 11 both
   // A result equal to its level counts as above
   // A level change alone never fires; it is judged at the next result
   // After reset the first result only sets the reference side
   // Hits stand one cycle per result

   // One crossing detector per input/threshold pair
   tcb_cmp_if cmp23 [N23] ();
   tcb_cmp_if cmp22 [N22] ();

   // Input 23: five pairs, A upward to level nine
   for (genvar k = 0; k < N23; k++) begin : g_det23
      assign cmp23[k].sampleValid = sample23Valid;
      assign cmp23[k].sample      = sample23;
      assign cmp23[k].level       = thr23[k];
      assign cmp23[k].sel         = input23EdgeIrqSelect[k*`TCB_SEL_W +: `TCB_SEL_W];
      assign in23Hit[k]           = cmp23[k].hit;
      tcb_edge_det u_det (
         .clock (clock),
         .rst_n (rst_n),
         .cmp   (cmp23[k])
      );
   end

   // Input 22: three pairs, A upward to C
   for (genvar k = 0; k < N22; k++) begin : g_det22
      assign cmp22[k].sampleValid = sample22Valid;
      assign cmp22[k].sample      = sample22;
      assign cmp22[k].level       = thr22[k];
      assign cmp22[k].sel         = input22EdgeIrqSelect[k*`TCB_SEL_W +: `TCB_SEL_W];
      assign in22Hit[k]           = cmp22[k].hit;
      tcb_edge_det u_det (
         .clock (clock),
         .rst_n (rst_n),
         .cmp   (cmp22[k])
      );
   end

   // Merged per-input event, registered so the output stays glitch free
   // The extra cycle is the price of a flip-flop on every output
   logic irq23_ff;
   logic irq22_ff;
   logic nxt_irq23;
   logic nxt_irq22;

   always_comb begin
      nxt_irq23 = |in23Hit;
      nxt_irq22 = |in22Hit;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irq23_ff <= 1'b0;
         irq22_ff <= 1'b0;
      end else begin
         irq23_ff <= nxt_irq23;
         irq22_ff <= nxt_irq22;
      end
   end

   assign in23Irq = irq23_ff;
   assign in22Irq = irq22_ff;

endmodule

`default_nettype wire

/* tb/tcb_bank_checker.sv */
// Purpose: Port checks of the threshold/edge config bank
// Assumes: One clock, sync active-low reset
// Notes:   Bound onto every tcb_bank
`timescale 1ns/100ps
`default_nettype none
`include "tcb_regs.svh"

module tcb_bank_checker
   import tcb_pkg::*;
(
   input  wire logic                      clock,                // Core clock
   input  wire logic                      rst_n,                // Sync reset
   input  wire logic                      regWrEn,              // Write strobe
   input  wire logic                      regRdEn,              // Read strobe
   input  wire tcb_addr_t                 regAddr,              // Offset
   input  wire tcb_word_t                 regWrData,            // Write word
   input  wire tcb_word_t                 regRdData,            // Read word
   input  wire logic                      regRdValid,           // Read pulse
   input  wire logic                      sample23Valid,        // New result
   input  wire tcb_level_t                sample23,             // Result
   input  wire tcb_level_t                sharedLevelA,         // Threshold A
   input  wire tcb_level_t [`TCB_LVL_NUM-1:0] levels,           // Levels
   input  wire logic [`TCB_SWITCH_INPUT_23_W-1:0]    input23EdgeIrqSelect, // Selects 23
   input  wire logic [`TCB_SWITCH_INPUT_22_W-1:0]    input22EdgeIrqSelect, // Selects 22
   input  wire logic [4:0]                in23Hit,              // Events 23
   input  wire logic [2:0]                in22Hit,              // Events 22
   input  wire logic                      in23Irq               // Irq 23
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // Register port: answer timing, reserved bits, field placement
   rd_answer_a: assert property (regRdEn |=> regRdValid) else $error("read not answered");
   rd_pulse_a: assert property (!regRdEn |=> !regRdValid) else $error("stray read pulse");
   rsvd_zero_a: assert property (regRdValid |-> regRdData[23:20] == 4'h0) else $error("reserved bits set");
   sel_write_a: assert property (regWrEn && regAddr == `TCB_OFS_IRQ_EN4 |=>
      input23EdgeIrqSelect == $past(regWrData[15:6]) && input22EdgeIrqSelect == $past(regWrData[5:0]))
      else $error("select field misplaced");
   lvl01_write_a: assert property (regWrEn && regAddr == `TCB_OFS_LVL01 |=>
      levels[1] == $past(regWrData[19:10]) && levels[0] == $past(regWrData[9:0])) else $error("level 0/1 wrong");
   lvl23_write_a: assert property (regWrEn && regAddr == `TCB_OFS_LVL23 |=>
      levels[3] == $past(regWrData[19:10]) && levels[2] == $past(regWrData[9:0])) else $error("level 2/3 wrong");
   lvl45_write_a: assert property (regWrEn && regAddr == `TCB_OFS_LVL45 |=>
      levels[5] == $past(regWrData[19:10]) && levels[4] == $past(regWrData[9:0])) else $error("level 4/5 wrong");
   lvl67_write_a: assert property (regWrEn && regAddr == `TCB_OFS_LVL67 |=>
      levels[7] == $past(regWrData[19:10]) && levels[6] == $past(regWrData[9:0])) else $error("level 6/7 wrong");

   // Events: only from a sample, only as the select allows, irq one cycle later
   hit_needs_sample_a: assert property (!sample23Valid |=> in23Hit == 5'h00) else $error("hit without sample");
   irq_follow_a: assert property (in23Irq == |$past(in23Hit)) else $error("irq not one cycle after hit");
   sel_none_a: assert property (in23Hit[0] |-> $past(input23EdgeIrqSelect[1:0]) != 2'b00) else $error("fired on 00");
   none22_a: assert property (in22Hit[2] |-> $past(input22EdgeIrqSelect[5:4]) != 2'b00) else $error("fired on 00");
   rise_only_a: assert property (in23Hit[0] && $past(input23EdgeIrqSelect[1:0]) == 2'b01 |->
      $past(sample23) >= $past(sharedLevelA)) else $error("rising select fired low");
   fall_only_a: assert property (in23Hit[0] && $past(input23EdgeIrqSelect[1:0]) == 2'b10 |->
      $past(sample23) < $past(sharedLevelA)) else $error("falling select fired high");
endmodule

bind tcb_bank tcb_bank_checker i_tcb_bank_checker (.clock(clock), .rst_n(rst_n), .regWrEn(regWrEn),
   .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
   .sample23Valid(sample23Valid), .sample23(sample23), .sharedLevelA(sharedLevelA), .levels(levels),
   .input23EdgeIrqSelect(input23EdgeIrqSelect), .input22EdgeIrqSelect(input22EdgeIrqSelect),
   .in23Hit(in23Hit), .in22Hit(in22Hit), .in23Irq(in23Irq));

`default_nettype wire

/* tb/tcb_host_model.sv */
// Purpose: Host side of the register port, one access per task call
// Assumes: Strobes sampled on the rising edge
// Notes:   Idle lines carry the inverse of the last value, never a stale copy
`timescale 1ns/100ps
`default_nettype none

module tcb_host_model
   import tcb_pkg::*;
(
   input  wire logic      clock,      // Core clock
   output var  logic      regWrEn,    // Write strobe
   output var  logic      regRdEn,    // Read strobe
   output var  tcb_addr_t regAddr,    // Word offset
   output var  tcb_word_t regWrData,  // Write word
   input  wire tcb_word_t regRdData,  // Read word
   input  wire logic      regRdValid  // Read answer pulse
);
   // Quiet port at time zero
   initial begin
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 6'h00;
      regWrData = 24'h000000;
   end

   // Gap lets the host run slow; at zero one idle cycle still separates two calls
   task automatic wr(input tcb_addr_t a, input tcb_word_t d, input int gap);
      repeat (gap) @(posedge clock);
      @(posedge clock);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWrEn <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
   endtask

   // Answer is taken once the read edge has landed
   task automatic rd(input tcb_addr_t a, output tcb_word_t d, output logic v, input int gap);
      repeat (gap) @(posedge clock);
      @(posedge clock);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRdEn <= 1'b0;
      regAddr <= ~a;
      #1;
      v = regRdValid;
      d = regRdData;
   endtask
endmodule

`default_nettype wire

/* tb/test_tcb_bank.sv */
// Purpose: Self-checking bench of the threshold/edge config bank
// Assumes: Default start value of levels six and seven
// Notes:   Two passes, a second reset between them
`timescale 1ns/100ps
`default_nettype none
`include "tcb_regs.svh"

module test_tcb_bank;
   import tcb_pkg::*;
   logic clock, rst_n, regWrEn, regRdEn, regRdValid, s23V, s22V, in23Irq, in22Irq, known, v;
   tcb_addr_t regAddr;
   tcb_word_t regWrData, regRdData, g;
   tcb_level_t s23, s22;
   tcb_level_t thr [5];
   tcb_level_t [`TCB_LVL_NUM-1:0] levels;
   logic [9:0] sel23;
   logic [5:0] sel22;
   logic [4:0] in23Hit;
   logic [2:0] in22Hit;
   logic side23 [5];
   logic side22 [3];
   int fails = 0, cmp_count = 0, cyc = 0;

   tcb_bank i_tcb_bank (.clock(clock), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
      .sample23Valid(s23V), .sample23(s23), .sample22Valid(s22V), .sample22(s22),
      .sharedLevelA(thr[0]), .sharedLevelB(thr[1]), .sharedLevelC(thr[2]), .levelEight(thr[3]),
      .levelNine(thr[4]), .levels(levels), .input23EdgeIrqSelect(sel23), .input22EdgeIrqSelect(sel22),
      .in23Hit(in23Hit), .in22Hit(in22Hit), .in23Irq(in23Irq), .in22Irq(in22Irq));
   tcb_host_model i_tcb_host_model (.clock(clock), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));

   task automatic chkReg(input tcb_word_t e, input tcb_word_t r);
      cmp_count++;
      if (e !== r) begin
         fails++;
         $display("Error at %0t: expected %h got %h", $time, e, r);
      end
   endtask
   task automatic chkEvt(input logic [7:0] e, input logic [7:0] r);
      cmp_count++;
      if (e !== r) begin
         fails++;
         $display("Error at %0t: expected %h got %h", $time, e, r);
      end
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Readable word after a write; unmapped offsets read zero
   function automatic tcb_word_t expWord(input tcb_addr_t a, input tcb_word_t d);
      if (a == `TCB_OFS_IRQ_EN4) return {8'h00, d[15:0]};
      if (a >= `TCB_OFS_LVL01 && a <= `TCB_OFS_LVL67) return {4'h0, d[19:0]};
      return 24'h000000;
   endfunction
   // Same word rebuilt from the held field outputs
   function automatic tcb_word_t portWord(input tcb_addr_t a);
      int k;
      k = 2 * (int'(a) - 'h29);
      if (a == `TCB_OFS_IRQ_EN4) return {8'h00, sel23, sel22};
      return {4'h0, levels[k+1], levels[k]};
   endfunction
   function automatic logic hitf(input tcb_sel_t s, input logic was, input logic now);
      return (s[`TCB_SEL_RISE_BIT] & !was & now) | (s[`TCB_SEL_FALL_BIT] & was & !now);
   endfunction

   task automatic doReset();
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      known = 1'b0;
   endtask

   task automatic testRegs();
      tcb_addr_t a;
      tcb_word_t d;
      // Reset contents of all five registers plus one unmapped offset
      for (int i = 0; i < 6; i++) begin
         i_tcb_host_model.rd(6'h28 + 6'(i), g, v, 0);
         chkReg(24'h000001, 24'(v));
         chkReg(24'h000000, g);
      end
      // All-ones first, so reserved bits are hit, then random words
      for (int i = 0; i < 40; i++) begin
         a = (i < 8) ? 6'h28 + 6'(i) : 6'h28 + 6'($urandom % 8);
         d = (i < 8) ? 24'hffffff : tcb_word_t'($urandom);
         i_tcb_host_model.wr(a, d, $urandom % 3);
         // Fields update on the strobe edge itself; look once they have settled
         #1;
         if (expWord(a, 24'hffffff) != 24'h0) chkReg(expWord(a, d), portWord(a));
         i_tcb_host_model.rd(a, g, v, $urandom % 3);
         chkReg(expWord(a, d), g);
      end
      $display("Test regs done, fails %0d", fails);
   endtask

   task automatic testEdges();
      logic [7:0] e;
      logic [15:0] w;
      logic now;
      @(posedge clock);
      foreach (thr[t]) thr[t] <= 10'(300 + $urandom % 400);
      for (int r = 0; r < 120; r++) begin
         // One code in every pair for the first four groups, then mixed codes
         if (r % 15 == 0) begin
            w = (r < 60) ? {8{2'(r / 15)}} : 16'($urandom);
            i_tcb_host_model.wr(`TCB_OFS_IRQ_EN4, {8'h00, w}, 0);
         end
         @(posedge clock);
         s23V <= 1'b1;
         s22V <= 1'b1;
         s23 <= (r % 7 == 3) ? thr[r % 5] : 10'($urandom);
         s22 <= (r % 7 == 5) ? thr[r % 3] : 10'($urandom);
         @(posedge clock);
         s23V <= 1'b0;
         s22V <= 1'b0;
         s23 <= ~s23;
         s22 <= ~s22;
         e = 8'h00;
         for (int t = 0; t < 5; t++) begin
            now = s23 >= thr[t];
            e[t+3] = known & hitf(w[6+2*t +: 2], side23[t], now);
            side23[t] = now;
         end
         for (int t = 0; t < 3; t++) begin
            now = s22 >= thr[t];
            e[t] = known & hitf(w[2*t +: 2], side22[t], now);
            side22[t] = now;
         end
         known = 1'b1;
         #1 chkEvt(e, {in23Hit, in22Hit});
         @(posedge clock);
         #1 chkEvt({6'h00, |e[7:3], |e[2:0]}, {6'h00, in23Irq, in22Irq});
      end
      $display("Test edges done, fails %0d", fails);
   endtask

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // Hang guard, far above the expected 1300 or so cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end

   initial begin
      rst_n = 1'b0;
      s23V = 1'b0;
      s22V = 1'b0;
      s23 = 10'h000;
      s22 = 10'h000;
      foreach (thr[t]) thr[t] = 10'h000;
      void'($urandom(55));
      for (int p = 0; p < 2; p++) begin
         doReset();
         testRegs();
         testEdges();
      end
      finish_test();
   end
endmodule

`default_nettype wire
